/* rtl/dtm_regs.vh */
`ifndef DTM_REGS_VH
`define DTM_REGS_VH
// Register addresses (8-bit special-register space)
`define DTM_ADDR_CTRL     8'h88
`define DTM_ADDR_MODE     8'h89
`define DTM_ADDR_LOW0     8'h8a
`define DTM_ADDR_LOW1     8'h8b
`define DTM_ADDR_HIGH0    8'h8c
`define DTM_ADDR_HIGH1    8'h8d
`define DTM_ADDR_IRQ_STAT 8'h8e
`define DTM_ADDR_IRQ_MASK 8'h8f
// Mode register fields
`define DTM_U1_GATE       7
`define DTM_U1_CSEL       6
`define DTM_U1_MODE_HI    5
`define DTM_U1_MODE_LO    4
`define DTM_U0_GATE       3
`define DTM_U0_CSEL       2
`define DTM_U0_MODE_HI    1
`define DTM_U0_MODE_LO    0
// Control register fields
`define DTM_U1_FLAG       7
`define DTM_U1_RUN        6
`define DTM_U0_FLAG       5
`define DTM_U0_RUN        4
// Mode encodings
`define DTM_MODE_PRE13    2'h0
`define DTM_MODE_CNT16    2'h1
`define DTM_MODE_RELOAD8  2'h2
`define DTM_MODE_SPLIT    2'h3
// Prescaler width in mode 00
`define DTM_PRESCALE_MAX  5'h1f
// Reset values
`define DTM_RST_BYTE      8'h00
`define DTM_RST_IRQ       2'h0
`endif

/* rtl/dtm_timer.v */
// Function
// - With the unit 1 gate bit set, unit 1 counts only while its external interrupt pin is high and its run bit is set, otherwise the run bit alone enables it.
// - With the unit 0 gate bit at bit 3 set, unit 0 counts only while its external interrupt pin is high and its run bit is set, otherwise the run bit alone enables it.
// - Unit 0 select bit 2 picks the internal clock when clear and falling edges of the unit 0 count pin when set.
// - Mode 00 makes the high byte an 8-bit counter behind a 5-bit prescaler in the low byte.
// - Mode 01 makes the two bytes one 16-bit counter with no prescaler.
// - Mode 10 counts in the low byte and reloads it from the high byte on overflow.
// - In unit 0 mode 11 the unit 0 low byte is an 8-bit counter under the normal unit 0 controls.
// - In unit 0 mode 11 the unit 0 high byte counts the internal clock only, under unit 1 controls.
// - Unit 1 in its own mode 11 stops and holds its value.
// - Overflow sets a unit's flag (in unit 0 mode 11 the unit 0 high byte sets unit 1's), service entry clears it, and software may set or clear it.
//
// Local design decision: the strobed register port.
`include "dtm_regs.vh"
`default_nettype none
module dtm_timer (
  input  wire       clk_i,
  input  wire       srst_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire       ext_irq0_pin_i,
  input  wire       ext_irq1_pin_i,
  input  wire       unit0_count_pin_i,
  input  wire       unit1_count_pin_i,
  input  wire       unit0_service_i,
  input  wire       unit1_service_i,
  output reg        unit0_overflow_flag_o,
  output reg        unit1_overflow_flag_o,
  output reg        irq_o
);

  reg  [7:0] timer_mode_select_ff;
  reg        unit0_run_ff;
  reg        unit1_run_ff;
  reg  [7:0] unit0_low_byte_ff;
  reg  [7:0] unit0_high_byte_ff;
  reg  [7:0] unit1_low_byte_ff;
  reg  [7:0] unit1_high_byte_ff;
  reg  [1:0] irq_stat_ff;
  reg  [1:0] irq_mask_ff;
  reg        cnt0_pin_d_ff;
  reg        cnt1_pin_d_ff;

  // Gated enable: run bit, optionally qualified by the interrupt pin
  function gate_ok;
    input run;
    input gate;
    input pin;
    begin
      gate_ok = run & (~gate | pin);
    end
  endfunction

  // Address decode shared by every register write
  function hit;
    input       strobe;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = strobe & (addr == target);
    end
  endfunction

  // One counting step: 16 bits plus carry out of the counting stage
  // Both units use this, so one copy of the mode arithmetic serves both
  function [16:0] step;
    input [1:0] mode;
    input [7:0] lo;
    input [7:0] hi;
    reg   [8:0] s;
    begin
      s = 9'h000;
      case (mode)
        `DTM_MODE_PRE13: begin
          // Upper three low-byte bits are left alone, as software wrote them
          if (lo[4:0] == `DTM_PRESCALE_MAX) begin
            s    = {1'b0, hi} + 9'h001;
            step = {s[8], s[7:0], lo[7:5], 5'h00};
          end else begin
            step = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
          end
        end
        `DTM_MODE_CNT16: begin
          step = {1'b0, hi, lo} + 17'h0_0001;
        end
        `DTM_MODE_RELOAD8: begin
          // High byte is only a reload store here, it never counts
          if (lo == 8'hff) begin
            step = {1'b1, hi, hi};
          end else begin
            step = {1'b0, hi, lo + 8'h01};
          end
        end
        default: begin
          // Split mode is handled outside; here the unit simply holds
          step = {1'b0, hi, lo};
        end
      endcase
    end
  endfunction

  wire [1:0] mode0 = timer_mode_select_ff[`DTM_U0_MODE_HI:`DTM_U0_MODE_LO];
  wire [1:0] mode1 = timer_mode_select_ff[`DTM_U1_MODE_HI:`DTM_U1_MODE_LO];
  wire       split = (mode0 == `DTM_MODE_SPLIT);

  // Falling edge detect on count pins, inputs are already synchronous
  // A pin must stay low one clock to be seen, so slow edges only
  wire fall0 = cnt0_pin_d_ff & ~unit0_count_pin_i;
  wire fall1 = cnt1_pin_d_ff & ~unit1_count_pin_i;

  // Increment sources selected by the counter-select bits
  wire src0 = timer_mode_select_ff[`DTM_U0_CSEL] ? fall0 : 1'b1;
  wire src1 = timer_mode_select_ff[`DTM_U1_CSEL] ? fall1 : 1'b1;

  wire en0 = gate_ok(unit0_run_ff, timer_mode_select_ff[`DTM_U0_GATE],
                     ext_irq0_pin_i);
  wire en1 = gate_ok(unit1_run_ff, timer_mode_select_ff[`DTM_U1_GATE],
                     ext_irq1_pin_i);

  // Per-clock increment requests for each counting stage
  wire tick0 = en0 & src0;
  // Split high byte ignores select bit: internal clock only
  wire tick0h = split & en1;
  wire tick1 = en1 & src1 & (mode1 != `DTM_MODE_SPLIT);

  wire [16:0] nxt_u0 = step(mode0, unit0_low_byte_ff, unit0_high_byte_ff);
  wire [16:0] nxt_u1 = step(mode1, unit1_low_byte_ff, unit1_high_byte_ff);
  wire [8:0]  nxt_split_lo = {1'b0, unit0_low_byte_ff} + 9'h001;
  wire [8:0]  nxt_split_hi = {1'b0, unit0_high_byte_ff} + 9'h001;

  // Overflow is the carry out of the stage that is counting this cycle
  wire ovf0 = tick0 & (split ? nxt_split_lo[8] : nxt_u0[16]);
  // In split mode unit 1 keeps running but its flag belongs to the high byte
  wire ovf1 = split ? (tick0h & nxt_split_hi[8]) : (tick1 & nxt_u1[16]);

  // Write strobes per register; unmapped addresses simply match none
  wire wr_ctrl  = hit(wr_i, addr_i, `DTM_ADDR_CTRL);
  wire wr_mode  = hit(wr_i, addr_i, `DTM_ADDR_MODE);
  wire wr_low0  = hit(wr_i, addr_i, `DTM_ADDR_LOW0);
  wire wr_low1  = hit(wr_i, addr_i, `DTM_ADDR_LOW1);
  wire wr_high0 = hit(wr_i, addr_i, `DTM_ADDR_HIGH0);
  wire wr_high1 = hit(wr_i, addr_i, `DTM_ADDR_HIGH1);
  wire wr_stat  = hit(wr_i, addr_i, `DTM_ADDR_IRQ_STAT);
  wire wr_mask  = hit(wr_i, addr_i, `DTM_ADDR_IRQ_MASK);

  // Clear first, then set, so an event in the clear cycle is never lost
  wire [1:0] ovf_vec      = {ovf1, ovf0};
  wire [1:0] clr_vec      = wr_stat ? wdata_i[1:0] : 2'h0;
  wire [1:0] nxt_irq_stat = (irq_stat_ff & ~clr_vec) | ovf_vec;
  // Using the next mask keeps the pin in step with the mask register
  wire [1:0] nxt_irq_mask = wr_mask ? wdata_i[1:0] : irq_mask_ff;

  // Pin history for edge detection
  // Reset to the idle high level so release never fakes a falling edge
  always @(posedge clk_i) begin
    if (srst_i) begin
      cnt0_pin_d_ff <= 1'b1;
      cnt1_pin_d_ff <= 1'b1;
    end else begin
      cnt0_pin_d_ff <= unit0_count_pin_i;
      cnt1_pin_d_ff <= unit1_count_pin_i;
    end
  end

  // Mode and run bits
  // A mode change takes effect on the next clock, mid-count if running
  always @(posedge clk_i) begin
    if (srst_i) begin
      timer_mode_select_ff <= `DTM_RST_BYTE;
      unit0_run_ff         <= 1'b0;
      unit1_run_ff         <= 1'b0;
      irq_mask_ff          <= `DTM_RST_IRQ;
    end else begin
      if (wr_mode) begin
        timer_mode_select_ff <= wdata_i;
      end
      if (wr_ctrl) begin
        unit0_run_ff <= wdata_i[`DTM_U0_RUN];
        unit1_run_ff <= wdata_i[`DTM_U1_RUN];
      end
      if (wr_mask) begin
        irq_mask_ff <= wdata_i[1:0];
      end
    end
  end

  // Overflow flags: hardware set beats any clear in the same cycle
  // Trade-off: a software clear racing an overflow is ignored, never lost
  always @(posedge clk_i) begin
    if (srst_i) begin
      unit0_overflow_flag_o <= 1'b0;
      unit1_overflow_flag_o <= 1'b0;
    end else begin
      if (ovf0) begin
        unit0_overflow_flag_o <= 1'b1;
      end else if (wr_ctrl) begin
        unit0_overflow_flag_o <= wdata_i[`DTM_U0_FLAG];
      end else if (unit0_service_i) begin
        unit0_overflow_flag_o <= 1'b0;
      end
      if (ovf1) begin
        unit1_overflow_flag_o <= 1'b1;
      end else if (wr_ctrl) begin
        unit1_overflow_flag_o <= wdata_i[`DTM_U1_FLAG];
      end else if (unit1_service_i) begin
        unit1_overflow_flag_o <= 1'b0;
      end
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  always @(posedge clk_i) begin
    if (srst_i) begin
      irq_stat_ff <= `DTM_RST_IRQ;
      irq_o       <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_o       <= |(nxt_irq_stat & nxt_irq_mask);
    end
  end

  // Unit 0 count bytes; a software write overrides counting
  // Write last so software always wins a same-cycle increment
  always @(posedge clk_i) begin
    if (srst_i) begin
      unit0_low_byte_ff  <= `DTM_RST_BYTE;
      unit0_high_byte_ff <= `DTM_RST_BYTE;
    end else begin
      if (split) begin
        if (tick0) begin
          unit0_low_byte_ff <= nxt_split_lo[7:0];
        end
        if (tick0h) begin
          unit0_high_byte_ff <= nxt_split_hi[7:0];
        end
      end else if (tick0) begin
        unit0_high_byte_ff <= nxt_u0[15:8];
        unit0_low_byte_ff  <= nxt_u0[7:0];
      end
      if (wr_low0) begin
        unit0_low_byte_ff <= wdata_i;
      end
      if (wr_high0) begin
        unit0_high_byte_ff <= wdata_i;
      end
    end
  end

  // Unit 1 count bytes; held while in its own mode 11
  // In split mode these still count, but their carry raises no flag
  always @(posedge clk_i) begin
    if (srst_i) begin
      unit1_low_byte_ff  <= `DTM_RST_BYTE;
      unit1_high_byte_ff <= `DTM_RST_BYTE;
    end else begin
      if (tick1) begin
        unit1_high_byte_ff <= nxt_u1[15:8];
        unit1_low_byte_ff  <= nxt_u1[7:0];
      end
      if (wr_low1) begin
        unit1_low_byte_ff <= wdata_i;
      end
      if (wr_high1) begin
        unit1_high_byte_ff <= wdata_i;
      end
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  // Zero when idle keeps a shared read bus free of stale bytes
  // Bytes are read one at a time, so a running 16-bit count may tear
  always @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= `DTM_RST_BYTE;
    end else if (rd_i) begin
      case (addr_i)
        `DTM_ADDR_CTRL:     rdata_o <= {unit1_overflow_flag_o, unit1_run_ff,
                                        unit0_overflow_flag_o, unit0_run_ff, 4'h0};
        `DTM_ADDR_MODE:     rdata_o <= timer_mode_select_ff;
        `DTM_ADDR_LOW0:     rdata_o <= unit0_low_byte_ff;
        `DTM_ADDR_LOW1:     rdata_o <= unit1_low_byte_ff;
        `DTM_ADDR_HIGH0:    rdata_o <= unit0_high_byte_ff;
        `DTM_ADDR_HIGH1:    rdata_o <= unit1_high_byte_ff;
        `DTM_ADDR_IRQ_STAT: rdata_o <= {6'h00, irq_stat_ff};
        `DTM_ADDR_IRQ_MASK: rdata_o <= {6'h00, irq_mask_ff};
        default:            rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule
`default_nettype wire

/* bench/dtm_timer_sva.sv */
`include "dtm_regs.vh"
`default_nettype none
module dtm_timer_sva (
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       unit0_service_i,
  input wire logic       unit1_service_i,
  input wire logic       unit0_overflow_flag_o,
  input wire logic       unit1_overflow_flag_o,
  input wire logic       irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Write to the control register
  wire ctl_wr = wr_i && addr_i == `DTM_ADDR_CTRL;
  wire ctl_rd = rd_i && addr_i == `DTM_ADDR_CTRL;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_flag0_sticky: assert property ($fell(unit0_overflow_flag_o) |->
    $past(unit0_service_i || ctl_wr || srst_i)) else $error("unit0 flag lost");
  a_flag1_sticky: assert property ($fell(unit1_overflow_flag_o) |->
    $past(unit1_service_i || ctl_wr || srst_i)) else $error("unit1 flag lost");
  a_irq_fall: assert property ($fell(irq_o) |-> $past(wr_i || srst_i))
    else $error("interrupt dropped without a write");
  a_ctrl_read: assert property (ctl_rd |=> rdata_o[7] == $past(unit1_overflow_flag_o)
    && rdata_o[5] == $past(unit0_overflow_flag_o) && rdata_o[3:0] == 4'h0)
    else $error("control readback wrong");
  a_unmapped_rd: assert property (rd_i && addr_i[7:3] != 5'h11 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_flag_set_sw: assert property (ctl_wr && wdata_i[7] |=> unit1_overflow_flag_o)
    else $error("software set of flag lost");
  a_mode_back: assert property (wr_i && addr_i == `DTM_ADDR_MODE ##1
    rd_i && addr_i == `DTM_ADDR_MODE |=> rdata_o == $past(wdata_i, 2))
    else $error("mode readback wrong");
endmodule
bind dtm_timer dtm_timer_sva u_sva (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .unit0_service_i(unit0_service_i), .unit1_service_i(unit1_service_i),
  .unit0_overflow_flag_o(unit0_overflow_flag_o),
  .unit1_overflow_flag_o(unit1_overflow_flag_o), .irq_o(irq_o));
`default_nettype wire

/* bench/dtm_pin_model.sv */
`default_nettype none
module dtm_pin_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] pulse_i,
  input  wire logic [1:0] gate_i,
  output var  logic [1:0] gate_o,
  output var  logic [1:0] count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hold_ff [0:1] = '{2'h0, 2'h0};
  // Count pins rest high so an idle line never fakes a falling edge
  always @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (pulse_i[i]) hold_ff[i] <= 2'h2;
      else if (hold_ff[i] != 2'h0) hold_ff[i] <= hold_ff[i] - 2'h1;
    end
  end
  assign count_o = {hold_ff[1] == 2'h0, hold_ff[0] == 2'h0};
  assign gate_o = gate_i;
endmodule
`default_nettype wire

/* bench/testbench.sv */
`include "dtm_regs.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, irq_o;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic [1:0] pulse = 2'h0, gate = 2'h0, svc = 2'h0, cnt, gpin, flg;
  int         n_fail = 0, total_checks = 0;
  always #4 clk_i = ~clk_i;
  dtm_pin_model u_pins (.clk_i(clk_i), .pulse_i(pulse), .gate_i(gate), .gate_o(gpin),
    .count_o(cnt));
  dtm_timer DUT (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_irq0_pin_i(gpin[0]),
    .ext_irq1_pin_i(gpin[1]), .unit0_count_pin_i(cnt[0]), .unit1_count_pin_i(cnt[1]),
    .unit0_service_i(svc[0]), .unit1_service_i(svc[1]), .unit0_overflow_flag_o(flg[0]),
    .unit1_overflow_flag_o(flg[1]), .irq_o(irq_o));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i) wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i) rd_i <= 1'b0;
    #1 check(rdata_o, exp);
    @(posedge clk_i);
  endtask
  task automatic pulses(input int u, input int n);
    repeat (n) begin
      pulse[u] <= 1'b1;
      @(posedge clk_i) pulse[u] <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000 n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    rd(`DTM_ADDR_MODE, 8'h00);
    rd(8'h90, 8'h00);
    wr(`DTM_ADDR_MODE, 8'h0d);
    wr(`DTM_ADDR_LOW0, 8'hfe);
    wr(`DTM_ADDR_HIGH0, 8'hff);
    wr(`DTM_ADDR_CTRL, 8'h10);
    pulses(0, 3);
    rd(`DTM_ADDR_LOW0, 8'hfe);
    gate <= 2'h3;
    pulses(0, 2);
    rd(`DTM_ADDR_LOW0, 8'h00);
    rd(`DTM_ADDR_HIGH0, 8'h00);
    rd(`DTM_ADDR_CTRL, 8'h30);
    #1 check({6'h00, flg}, 8'h01);
    svc <= 2'h1;
    @(posedge clk_i) svc <= 2'h0;
    @(posedge clk_i);
    rd(`DTM_ADDR_CTRL, 8'h10);
    #1 check({6'h00, flg}, 8'h00);
    wr(`DTM_ADDR_MODE, 8'h04);
    wr(`DTM_ADDR_LOW0, 8'hff);
    wr(`DTM_ADDR_HIGH0, 8'h00);
    pulses(0, 1);
    rd(`DTM_ADDR_LOW0, 8'he0);
    rd(`DTM_ADDR_HIGH0, 8'h01);
    wr(`DTM_ADDR_MODE, 8'h06);
    wr(`DTM_ADDR_LOW0, 8'hff);
    wr(`DTM_ADDR_HIGH0, 8'h40);
    pulses(0, 1);
    rd(`DTM_ADDR_LOW0, 8'h40);
    rd(`DTM_ADDR_CTRL, 8'h30);
    $display("unit0 modes done");
    gate <= 2'h0;
    wr(`DTM_ADDR_MODE, 8'hd0);
    wr(`DTM_ADDR_LOW1, 8'h05);
    wr(`DTM_ADDR_CTRL, 8'h40);
    pulses(1, 2);
    rd(`DTM_ADDR_LOW1, 8'h05);
    gate <= 2'h3;
    pulses(1, 2);
    rd(`DTM_ADDR_LOW1, 8'h07);
    wr(`DTM_ADDR_MODE, 8'hf0);
    pulses(1, 2);
    rd(`DTM_ADDR_LOW1, 8'h07);
    $display("unit1 done");
    wr(`DTM_ADDR_CTRL, 8'h00);
    wr(`DTM_ADDR_MODE, 8'h07);
    wr(`DTM_ADDR_LOW0, 8'hfe);
    wr(`DTM_ADDR_HIGH0, 8'h10);
    wr(`DTM_ADDR_CTRL, 8'h10);
    pulses(0, 1);
    rd(`DTM_ADDR_LOW0, 8'hff);
    rd(`DTM_ADDR_HIGH0, 8'h10);
    wr(`DTM_ADDR_HIGH0, 8'hfe);
    wr(`DTM_ADDR_CTRL, 8'h40);
    repeat (4) @(posedge clk_i);
    rd(`DTM_ADDR_CTRL, 8'hc0);
    #1 check({6'h00, flg}, 8'h02);
    svc <= 2'h2;
    @(posedge clk_i) svc <= 2'h0;
    @(posedge clk_i);
    #1 check({6'h00, flg}, 8'h00);
    wr(`DTM_ADDR_CTRL, 8'h00);
    $display("split done");
    rd(`DTM_ADDR_IRQ_STAT, 8'h03);
    #1 check({7'h0, irq_o}, 8'h00);
    wr(`DTM_ADDR_IRQ_MASK, 8'h02);
    #1 check({7'h0, irq_o}, 8'h01);
    wr(`DTM_ADDR_IRQ_STAT, 8'h02);
    #1 check({7'h0, irq_o}, 8'h00);
    rd(`DTM_ADDR_IRQ_STAT, 8'h01);
    $display("interrupt done");
    report_and_stop();
  end
endmodule
`default_nettype wire
